//--- fctu_pkg.sv
// fctu_pkg: constants and types for the fault context trap unit
// assumes a 32-bit classic wishbone register bus and a 32-bit memory port
package fctu_pkg;

  // ----------------------------------------------------------------
  // register map (word aligned byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] FCTU_OFS_CPB0   = 8'h00;
  localparam logic [7:0] FCTU_OFS_CPB1   = 8'h04;
  localparam logic [7:0] FCTU_OFS_CPB2   = 8'h08;
  localparam logic [7:0] FCTU_OFS_STATUS = 8'h0C;
  localparam logic [7:0] FCTU_OFS_CFG    = 8'h10;
  localparam logic [7:0] FCTU_OFS_FCODE  = 8'h14;
  localparam logic [7:0] FCTU_OFS_FSIZE  = 8'h18;
  localparam logic [7:0] FCTU_OFS_FADDR  = 8'h1C;
  localparam logic [7:0] FCTU_OFS_SP     = 8'h20;

  // ----------------------------------------------------------------
  // fields and fixed values
  // ----------------------------------------------------------------
  localparam int          FCTU_PAGE_LSB     = 12;
  localparam logic [31:0] FCTU_PAGE_MASK    = 32'hFFFFF000;
  localparam logic [31:0] FCTU_PAGE_BYTES   = 32'h00001000;
  localparam logic [1:0]  FCTU_FRL_CONTEXT  = 2'h0;
  localparam logic [1:0]  FCTU_FRL_EXTENDED = 2'h1;
  localparam logic [31:0] FCTU_VEC_EXC      = 32'h0000000C;
  localparam logic [31:0] FCTU_VEC_GHE      = 32'h00000020;
  localparam logic [31:0] FCTU_GHE_DSI_OK   = 32'h00003C01;
  localparam logic [31:0] FCTU_GHE_DSI_FAIL = 32'h00003C00;
  localparam logic [31:0] FCTU_ZERO         = 32'h00000000;
  localparam logic [31:0] FCTU_WORD         = 32'h00000004;
  localparam logic [31:0] FCTU_ALIGN_MASK   = 32'h00000003;

  // machine exception cause bits
  localparam int FCTU_MX_NESTED   = 0;
  localparam int FCTU_MX_SDR_NRES = 1;
  localparam int FCTU_MX_KDR_LATE = 2;
  localparam int FCTU_MX_DESCRIPTOR_REG_ZERO_INV = 3;
  localparam int FCTU_MX_STK_ALGN = 4;
  localparam int FCTU_MX_SDR_ALGN = 5;
  localparam int FCTU_MX_CMR_NRES = 6;
  localparam int FCTU_MX_SRS_UNDR = 7;

  typedef enum logic [3:0] {
    FCTU_IDLE, FCTU_SAVE, FCTU_ACQ, FCTU_PUSH, FCTU_LOAD, FCTU_VEC,
    FCTU_RCHK, FCTU_RPOP, FCTU_RREL, FCTU_RLOAD, FCTU_GPUSH, FCTU_GDSI,
    FCTU_HARD
  } fctu_state_type;

  // memory request carrier
  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [31:0] data;
  } fctu_mem_req_type;

  // processor-side event carrier
  typedef struct packed {
    logic        fault;
    logic        rtnc;
    logic        ghe;
    logic        idle;
    logic [31:0] fault_addr;
    logic [31:0] fault_code;
  } fctu_event_type;

endpackage

//--- fctu_unit.sv
// fctu_unit: fault entry, context return and global hard error trap sequencer
// assumes a single-word memory port answering with mem_ack_i and mem_fault_i
// How it works
// - on a fault, context is first saved to physical context pages
// - then a stack is taken and a context frame with length 00 pushed
// - frame size, fault address and fault code are loaded on entry
// - the handler pointer at 0x0000000c of page 0 is fetched last
// - the physical save never faults; later faults cause a hard error
// - context return first checks frame length bits equal 00
// - context return pops the frame and returns the stack pointer
// - context return reloads state from physical pages, never faulting
// - faults during return check or pop cause a hard error
// - a hard error broadcasts a nonmaskable trap to every processor
// - an active processor pushes an extended block and jumps to handler
// - an idle processor loads index, thread id and idle stack pointer
// - idle frame has return pc zero and frame length bits 01
// - idle sp and fp end at stack base less extended frame length
// - idle processor disables interrupts; code 3c01 or 3c00 results
// - execution then starts at the pointer held at location 0x20
// - three page bases take successive 4096-byte context portions
// - page bases write only in ring 0; bits 31..12 kept
// - nested protection or nonresident fault raises machine exception
// - descriptor load faults, late kernel load, invalid zero raise one
// - multiprocessor and uniprocessor variants raise their own subsets
`timescale 1ns/1ps
module fctu_unit
  import fctu_pkg::*;
#(
  parameter int          CTX_WORDS    = 16,
  parameter int          FRAME_WORDS  = 8,
  parameter int          EXT_WORDS    = 4,
  parameter bit          MULTI_CPU    = 1'b1,
  parameter logic [31:0] SRS_BASE     = 32'h00000100,
  parameter logic [31:0] PROC_ID      = 32'h00000001
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  // processor events
  input  wire fctu_event_type   evt_i,
  input  wire logic             ring0_i,
  input  wire logic             int_en_i,
  input  wire logic [31:0]      idle_commreg_index_i,
  input  wire logic [31:0]      idle_stack_i,
  input  wire logic             ghe_in_i,
  input  wire logic             nested_pf_i,
  input  wire logic             sdr_nres_i,
  input  wire logic             kdr_late_i,
  input  wire logic             descriptor_reg_zero_inv_i,
  input  wire logic             stk_unal_i,
  input  wire logic             sdr_unal_i,
  input  wire logic             cmr_nres_i,
  // memory port
  output fctu_mem_req_type      mem_o,
  input  wire logic             mem_ack_i,
  input  wire logic             mem_fault_i,
  input  wire logic [31:0]      mem_rdata_i,
  // processor results
  output logic                  busy_o,
  output logic                  dis_int_o,
  output logic                  pc_load_o,
  output logic [31:0]           pc_o,
  output logic [31:0]           frame_size_reg_o,
  output logic [31:0]           fault_address_reg_o,
  output logic [31:0]           fault_code_reg_o,
  output logic [31:0]           sp_o,
  output logic [31:0]           fp_o,
  output logic [31:0]           current_commreg_index_o,
  output logic [31:0]           thread_identifier_o,
  output logic                  ghe_out_o,
  output logic                  mach_exc_o,
  output logic [7:0]            mach_cause_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  fctu_state_type   st_reg, st_next;
  logic [31:0]      cpb_reg [3];
  logic [31:0]      cnt_reg;
  logic [31:0]      srs_reg;
  logic [31:0]      cfg_reg;
  logic [31:0]      ghe_pc_reg;
  fctu_event_type   ev_reg;
  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic [31:0]      cnt_next;
  logic [31:0]      sp_next;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        wb_wr    = wb_req & wb_we_i & (&wb_sel_i);
  wire        cpb_hit  = (wb_adr_i == FCTU_OFS_CPB0) | (wb_adr_i == FCTU_OFS_CPB1)
                       | (wb_adr_i == FCTU_OFS_CPB2);
  wire [1:0]  cpb_idx  = wb_adr_i[3:2];
  wire        cpb_wr   = wb_wr & cpb_hit & ring0_i;
  wire        cfg_wr   = wb_wr & (wb_adr_i == FCTU_OFS_CFG);
  wire [31:0] status_w = {19'h0, busy_o, ghe_out_o, mach_exc_o, 2'h0, mach_cause_o};
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      FCTU_OFS_CPB0:   rd_mux = cpb_reg[0];
      FCTU_OFS_CPB1:   rd_mux = cpb_reg[1];
      FCTU_OFS_CPB2:   rd_mux = cpb_reg[2];
      FCTU_OFS_STATUS: rd_mux = status_w;
      FCTU_OFS_CFG:    rd_mux = cfg_reg;
      FCTU_OFS_FCODE:  rd_mux = fault_code_reg_o;
      FCTU_OFS_FSIZE:  rd_mux = frame_size_reg_o;
      FCTU_OFS_FADDR:  rd_mux = fault_address_reg_o;
      FCTU_OFS_SP:     rd_mux = sp_o;
      default:         rd_mux = FCTU_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer addressing
  // ----------------------------------------------------------------
  localparam int PAGE_WORDS = 1024;
  wire [1:0]  page_sel   = 2'(cnt_next / PAGE_WORDS);
  wire [31:0] page_off   = 32'((cnt_next % PAGE_WORDS) * 4);
  wire [31:0] ctx_addr   = (cpb_reg[page_sel] & FCTU_PAGE_MASK) | page_off;
  wire [31:0] push_addr  = sp_next - FCTU_WORD;
  wire        last_ctx   = (cnt_reg == 32'(CTX_WORDS - 1));
  wire        last_frm   = (cnt_reg == 32'(FRAME_WORDS - 1));
  wire        last_ext   = (cnt_reg == 32'(EXT_WORDS - 1));
  wire [31:0] frm_bytes  = 32'(FRAME_WORDS * 4);
  wire [31:0] ext_bytes  = 32'(EXT_WORDS * 4);
  wire        step       = mem_ack_i & ~mem_fault_i;
  logic       ghe_m_reg, ghe_s_reg, ghe_d_reg, ghe_pend_reg;
  // one trap per rising edge of the trap pin, held until idle
  wire        ghe_rise   = ghe_s_reg & ~ghe_d_reg;
  wire        ghe_take   = (st_reg == FCTU_IDLE) & ghe_pend_reg;
  wire        ghe_sync   = ghe_pend_reg;
  wire        fault_risk = (st_reg == FCTU_ACQ) | (st_reg == FCTU_PUSH)
                         | (st_reg == FCTU_LOAD) | (st_reg == FCTU_VEC)
                         | (st_reg == FCTU_RCHK) | (st_reg == FCTU_RPOP)
                         | (st_reg == FCTU_RREL) | (st_reg == FCTU_GPUSH);
  wire        hard_err   = fault_risk & mem_ack_i & mem_fault_i;
  wire        srs_empty  = (st_reg == FCTU_ACQ) & step & (mem_rdata_i == FCTU_ZERO);
  wire [7:0]  mx_w;
  assign mx_w[FCTU_MX_NESTED]   = nested_pf_i | (hard_err & (st_reg == FCTU_PUSH));
  assign mx_w[FCTU_MX_SDR_NRES] = sdr_nres_i;
  assign mx_w[FCTU_MX_KDR_LATE] = kdr_late_i;
  assign mx_w[FCTU_MX_DESCRIPTOR_REG_ZERO_INV] = descriptor_reg_zero_inv_i;
  assign mx_w[FCTU_MX_STK_ALGN] = ~MULTI_CPU & stk_unal_i;
  assign mx_w[FCTU_MX_SDR_ALGN] = ~MULTI_CPU & sdr_unal_i;
  assign mx_w[FCTU_MX_CMR_NRES] = MULTI_CPU & cmr_nres_i;
  assign mx_w[FCTU_MX_SRS_UNDR] = MULTI_CPU & srs_empty;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      FCTU_IDLE: begin
        if (ghe_sync & evt_i.idle) st_next = FCTU_GPUSH;
        else if (ghe_sync) st_next = FCTU_GPUSH;
        else if (evt_i.fault) st_next = FCTU_SAVE;
        else if (evt_i.rtnc) st_next = FCTU_RCHK;
      end
      FCTU_SAVE:  if (mem_ack_i & last_ctx) st_next = FCTU_ACQ;
      FCTU_ACQ:   if (step) st_next = srs_empty ? FCTU_HARD : FCTU_PUSH;
      FCTU_PUSH:  if (step & last_frm) st_next = FCTU_LOAD;
      FCTU_LOAD:  st_next = FCTU_VEC;
      FCTU_VEC:   if (step) st_next = FCTU_IDLE;
      FCTU_RCHK: begin
        if (step) st_next = (mem_rdata_i[1:0] == FCTU_FRL_CONTEXT) ? FCTU_RPOP : FCTU_HARD;
      end
      FCTU_RPOP:  st_next = FCTU_RREL;
      FCTU_RREL:  if (step) st_next = FCTU_RLOAD;
      FCTU_RLOAD: if (mem_ack_i & last_ctx) st_next = FCTU_IDLE;
      FCTU_GPUSH: if (step & last_ext) st_next = ev_reg.idle ? FCTU_GDSI : FCTU_VEC;
      FCTU_GDSI:  st_next = FCTU_VEC;
      FCTU_HARD:  st_next = FCTU_IDLE;
      default:    st_next = FCTU_IDLE;
    endcase
    if (hard_err) st_next = FCTU_HARD;
  end

  // ----------------------------------------------------------------
  // count and stack pointer after this edge
  // ----------------------------------------------------------------
  assign cnt_next = (st_next != st_reg) ? FCTU_ZERO : mem_ack_i ? cnt_reg + 32'h1 : cnt_reg;
  wire        last_frm_n = (cnt_next == 32'(FRAME_WORDS - 1));
  wire        last_ext_n = (cnt_next == 32'(EXT_WORDS - 1));
  always_comb begin
    sp_next = sp_o;
    if (st_reg == FCTU_IDLE && ghe_sync && evt_i.idle) sp_next = idle_stack_i;
    if (st_reg == FCTU_ACQ && step) sp_next = mem_rdata_i;
    if ((st_reg == FCTU_PUSH || st_reg == FCTU_GPUSH) && step) sp_next = sp_o - FCTU_WORD;
    if (st_reg == FCTU_RPOP) sp_next = sp_o + frm_bytes;
  end

  // ----------------------------------------------------------------
  // memory request
  // ----------------------------------------------------------------
  fctu_mem_req_type req_next;
  always_comb begin
    req_next = '0;
    case (st_next)
      FCTU_SAVE:  req_next = '{1'b1, 1'b1, ctx_addr, FCTU_ZERO};
      FCTU_ACQ:   req_next = '{1'b1, 1'b0, srs_reg, FCTU_ZERO};
      FCTU_PUSH:  req_next = '{1'b1, 1'b1, push_addr,
                    last_frm_n ? {30'h0, FCTU_FRL_CONTEXT} : cnt_next};
      FCTU_VEC:   req_next = '{1'b1, 1'b0, ghe_pc_reg, FCTU_ZERO};
      FCTU_RCHK:  req_next = '{1'b1, 1'b0, sp_next, FCTU_ZERO};
      FCTU_RREL:  req_next = '{1'b1, 1'b1, srs_reg, sp_next};
      FCTU_RLOAD: req_next = '{1'b1, 1'b0, ctx_addr, FCTU_ZERO};
      FCTU_GPUSH: req_next = '{1'b1, 1'b1, push_addr,
                    last_ext_n ? {30'h0, FCTU_FRL_EXTENDED} : FCTU_ZERO};
      default:    req_next = '0;
    endcase
    if (mem_o.valid & ~mem_ack_i) req_next = mem_o;
  end

  // ----------------------------------------------------------------
  // clocked state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= FCTU_IDLE;
      cnt_reg <= FCTU_ZERO;
      ack_reg <= 1'b0;
      dat_reg <= FCTU_ZERO;
      ghe_m_reg <= 1'b0;
      ghe_s_reg <= 1'b0;
      ghe_d_reg <= 1'b0;
      ghe_pend_reg <= 1'b0;
      ev_reg <= '0;
      mem_o <= '0;
    end else begin
      ghe_m_reg <= ghe_in_i;
      ghe_s_reg <= ghe_m_reg;
      ghe_d_reg <= ghe_s_reg;
      ghe_pend_reg <= ghe_rise | (ghe_pend_reg & ~ghe_take);
      ack_reg <= wb_req;
      dat_reg <= rd_mux;
      st_reg <= st_next;
      mem_o <= req_next;
      if (st_reg == FCTU_IDLE) ev_reg <= evt_i;
      cnt_reg <= cnt_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpb_reg <= '{default: FCTU_ZERO};
      cfg_reg <= FCTU_ZERO;
      srs_reg <= SRS_BASE;
      ghe_pc_reg <= FCTU_VEC_EXC;
    end else begin
      if (cpb_wr) cpb_reg[cpb_idx] <= wb_dat_i & FCTU_PAGE_MASK;
      if (cfg_wr) srs_reg <= wb_dat_i;
      if (cfg_wr) cfg_reg <= wb_dat_i;
      if (st_next == FCTU_GPUSH && st_reg == FCTU_IDLE) ghe_pc_reg <= FCTU_VEC_GHE;
      else if (st_next == FCTU_SAVE) ghe_pc_reg <= FCTU_VEC_EXC;
    end
  end

  // ----------------------------------------------------------------
  // architectural results
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      dis_int_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_o <= FCTU_ZERO;
      frame_size_reg_o <= FCTU_ZERO;
      fault_address_reg_o <= FCTU_ZERO;
      fault_code_reg_o <= FCTU_ZERO;
      sp_o <= FCTU_ZERO;
      fp_o <= FCTU_ZERO;
      current_commreg_index_o <= FCTU_ZERO;
      thread_identifier_o <= FCTU_ZERO;
      ghe_out_o <= 1'b0;
      mach_exc_o <= 1'b0;
      mach_cause_o <= 8'h00;
    end else begin
      busy_o <= (st_next != FCTU_IDLE);
      pc_load_o <= 1'b0;
      dis_int_o <= 1'b0;
      ghe_out_o <= (st_next == FCTU_HARD);
      mach_exc_o <= |mx_w;
      mach_cause_o <= mx_w;
      if (st_reg == FCTU_IDLE && ghe_sync && evt_i.idle) begin
        current_commreg_index_o <= idle_commreg_index_i;
        thread_identifier_o <= PROC_ID;
      end
      sp_o <= sp_next;
      if (st_reg == FCTU_GPUSH && step && last_ext && ev_reg.idle) begin
        fp_o <= sp_next;
      end
      if (st_reg == FCTU_LOAD) begin
        frame_size_reg_o <= frm_bytes;
        fault_address_reg_o <= ev_reg.fault_addr;
        fault_code_reg_o <= ev_reg.fault_code;
      end
      if (st_reg == FCTU_GDSI) begin
        dis_int_o <= 1'b1;
        fault_code_reg_o <= int_en_i ? FCTU_GHE_DSI_OK : FCTU_GHE_DSI_FAIL;
        frame_size_reg_o <= ext_bytes;
      end
      if (st_reg == FCTU_VEC && step) begin
        pc_load_o <= 1'b1;
        pc_o <= mem_rdata_i;
      end
    end
  end

endmodule

//--- fctu_unit_assertions.sv
// fctu_unit_assertions: port level checks for fctu_unit
// assumes binding onto fctu_unit, one clock, rst_i synchronous active high
`timescale 1ns/1ps
module fctu_unit_chk
  import fctu_pkg::*;
#(
  parameter bit MULTI_CPU = 1'b1
) (
  // clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // register bus
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  // events and conditions
  input wire fctu_event_type   evt_i,
  input wire logic             nested_pf_i,
  input wire logic             sdr_nres_i,
  input wire logic             stk_unal_i,
  input wire logic             cmr_nres_i,
  // results
  input wire fctu_mem_req_type mem_o,
  input wire logic             busy_o,
  input wire logic             pc_load_o,
  input wire logic [31:0]      sp_o,
  input wire logic [31:0]      fp_o,
  input wire logic             ghe_out_o,
  input wire logic             mach_exc_o,
  input wire logic [7:0]       mach_cause_o
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_fault_start;
    evt_i.fault && !busy_o;
  endsequence
  sequence s_ctx_write;
    mem_o.valid && mem_o.we;
  endsequence
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ctx_first: assert property (s_fault_start |-> ##[1:4] s_ctx_write)
    else $error("fault entry did not start with a context write");
  chk_ghe_pulse: assert property (ghe_out_o |=> !ghe_out_o)
    else $error("hard error broadcast not a pulse");
  chk_mach_nested: assert property (nested_pf_i |=> mach_exc_o && mach_cause_o[0])
    else $error("nested fault without machine exception");
  chk_mach_sdr: assert property (sdr_nres_i |=> mach_exc_o && mach_cause_o[1])
    else $error("descriptor nonresident without machine exception");
  chk_mach_cmr: assert property (cmr_nres_i |=> mach_cause_o[6] == MULTI_CPU)
    else $error("commreg cause wrong for this variant");
  chk_mach_stack: assert property (stk_unal_i |=> mach_cause_o[4] != MULTI_CPU)
    else $error("stack alignment cause wrong for this variant");
  chk_idle_sp_fp: assert property (pc_load_o && evt_i.idle |-> sp_o == fp_o)
    else $error("idle trap left sp and fp apart");
endmodule
bind fctu_unit fctu_unit_chk #(.MULTI_CPU(MULTI_CPU)) u_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .evt_i, .nested_pf_i, .sdr_nres_i, .stk_unal_i, .cmr_nres_i, .mem_o,
  .busy_o, .pc_load_o, .sp_o, .fp_o, .ghe_out_o, .mach_exc_o, .mach_cause_o);

//--- fctu_unit_tb_top.sv
// fctu_unit_tb_top: directed bench for fctu_unit
// assumes the bench answers the memory port itself, one cycle per request
`timescale 1ns/1ps
module fctu_unit_tb_top
  import fctu_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [31:0] H_EXC = 32'h00004000;
  localparam logic [31:0] H_GHE = 32'h00005000;
  localparam logic [31:0] STK   = 32'h00008000;
  localparam logic [31:0] PID   = 32'h00000007;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ring0_i = 1;
  logic int_en_i = 0, ghe_in_i = 0, mem_ack_i = 0, mem_fault_i = 0;
  logic ghe_seen = 0, dis_seen = 0, got_first = 0, vec_seen = 0, srs_wr = 0, und_seen = 0;
  logic [19:0] cur_pg = 20'h00012;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [6:0] mx = 7'h00;
  logic [31:0] wb_dat_i = 0, mem_rdata_i = 0, top_word = 0, bad_addr = 32'hFFFFFFFC;
  logic [31:0] first_a, last_ra, q, wb_dat_o, pc_o, fault_address_reg_o, fault_code_reg_o;
  logic [31:0] sp_o, fp_o, current_commreg_index_o, thread_identifier_o, frame_size_reg_o, last_wd;
  logic wb_ack_o, busy_o, dis_int_o, pc_load_o, ghe_out_o, mach_exc_o;
  logic [7:0] mach_cause_o;
  fctu_event_type evt_i = '0;
  fctu_mem_req_type mem_o;
  int err_total = 0, checks_done = 0, cyc_n = 0;
  fctu_unit #(.CTX_WORDS(4), .FRAME_WORDS(2), .EXT_WORDS(2), .PROC_ID(PID)) u_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .evt_i, .ring0_i, .int_en_i,
    .idle_commreg_index_i(32'h00000033), .idle_stack_i(32'h00009000), .ghe_in_i,
    .nested_pf_i(mx[0]), .sdr_nres_i(mx[1]), .kdr_late_i(mx[2]), .descriptor_reg_zero_inv_i(mx[3]),
    .stk_unal_i(mx[4]), .sdr_unal_i(mx[5]), .cmr_nres_i(mx[6]), .mem_o, .mem_ack_i,
    .mem_fault_i, .mem_rdata_i, .busy_o, .dis_int_o, .pc_load_o, .pc_o,
    .frame_size_reg_o, .fault_address_reg_o, .fault_code_reg_o, .sp_o, .fp_o,
    .current_commreg_index_o, .thread_identifier_o, .ghe_out_o, .mach_exc_o, .mach_cause_o);
  // ----------------------------------------------------------------
  // clock, memory responder, timeout
  // ----------------------------------------------------------------
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    mem_ack_i <= 1'b0;
    if (ghe_out_o) ghe_seen <= 1'b1;
    if (dis_int_o) dis_seen <= 1'b1;
    if (mach_cause_o[7]) und_seen <= 1'b1;
    if (mem_o.valid && !mem_ack_i) begin
      mem_ack_i <= 1'b1;
      mem_fault_i <= mem_o.addr == bad_addr;
      mem_rdata_i <= mem_o.addr == FCTU_VEC_EXC ? H_EXC : mem_o.addr == FCTU_VEC_GHE ? H_GHE :
                     mem_o.addr == 32'h00000100 ? STK : top_word;
      if (!got_first) first_a <= mem_o.addr;
      got_first <= 1'b1;
      if (!mem_o.we) last_ra <= mem_o.addr;
      if (mem_o.we) last_wd <= mem_o.data;
      if (!mem_o.we && mem_o.addr == FCTU_VEC_EXC) vec_seen <= 1'b1;
      if (mem_o.we && mem_o.addr == 32'h00000100) srs_wr <= 1'b1;
    end
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      err_total++;
      end_of_test;
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic clr();
    @(posedge clk_i);
    {ghe_seen, dis_seen, got_first, vec_seen, srs_wr, und_seen} <= 6'h00;
  endtask
  task automatic pulse(input logic f, input logic r);
    @(posedge clk_i);
    evt_i.fault <= f;
    evt_i.rtnc <= r;
    @(posedge clk_i);
    {evt_i.fault, evt_i.rtnc} <= 2'h0;
  endtask
  task automatic wait_pc();
    for (int n = 0; n < 3000 && pc_load_o !== 1'b1; n++) @(posedge clk_i);
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge clk_i);
    for (int n = 0; n < 3000 && busy_o !== 1'b0; n++) @(posedge clk_i);
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    wb(FCTU_OFS_CPB0, 1, 32'h00012ABC);
    wb(FCTU_OFS_CPB0, 0, 0);
    chk(q, 32'h00012000);
    ring0_i <= 1'b0;
    wb(FCTU_OFS_CPB1, 1, 32'h00034000);
    wb(FCTU_OFS_CPB1, 0, 0);
    chk(q, 32'h00000000);
    ring0_i <= 1'b1;
    wb(FCTU_OFS_CPB2, 1, 32'h00056FFF);
    wb(FCTU_OFS_CPB2, 0, 0);
    chk(q, 32'h00056000);
    wb(8'h40, 0, 0);
    chk(q, 32'h00000000);
    $display("test regs done");
  endtask
  task automatic t_fault();
    clr();
    evt_i.fault_addr <= 32'h0000BEEF;
    evt_i.fault_code <= 32'h00001001;
    pulse(1, 0);
    wait_pc();
    chk(pc_o, H_EXC);
    chk(vec_seen, 1);
    chk(first_a[31:12], cur_pg);
    chk(last_wd, 32'h00000000);
    chk(frame_size_reg_o, 32'h00000008);
    chk(fault_address_reg_o, 32'h0000BEEF);
    chk(fault_code_reg_o, 32'h00001001);
    wait_idle();
    chk(ghe_seen, 0);
    cur_pg = cur_pg + 20'h00001;
    wb(FCTU_OFS_CPB0, 1, {cur_pg, 12'h000});
    $display("test fault done");
  endtask
  task automatic t_rtnc(input logic [31:0] top, input logic bad);
    clr();
    top_word <= top;
    pulse(0, 1);
    wait_idle();
    chk(ghe_seen, bad);
    if (!bad) chk(srs_wr, 1);
    if (!bad) chk(last_ra[31:12], cur_pg);
    $display("test rtnc done");
  endtask
  task automatic t_mach();
    logic [7:0] e;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_i);
      mx <= 7'h01 << i;
      e = (i == 4 || i == 5) ? 8'h00 : 8'h01 << i;
      repeat (2) @(posedge clk_i);
      chk(mach_cause_o, e);
      chk(mach_exc_o, e != 8'h00);
    end
    mx <= 7'h00;
    $display("test mach done");
  endtask
  task automatic t_ghe(input logic idle, input logic ie, input logic [31:0] code);
    clr();
    evt_i.idle <= idle;
    int_en_i <= ie;
    ghe_in_i <= 1'b1;
    wait_pc();
    ghe_in_i <= 1'b0;
    chk(pc_o, H_GHE);
    chk(got_first, 1);
    chk(last_wd, 32'h00000001);
    if (idle) chk(first_a, 32'h00008FFC);
    if (idle) chk(fault_code_reg_o, code);
    if (idle) chk(current_commreg_index_o, 32'h00000033);
    if (idle) chk(thread_identifier_o, PID);
    if (idle) chk(sp_o, 32'h00008FF8);
    if (idle) chk(fp_o, 32'h00008FF8);
    wait_idle();
    if (idle && ie) chk(dis_seen, 1);
    evt_i.idle <= 1'b0;
    $display("test ghe done");
  endtask
  task automatic t_hard();
    clr();
    bad_addr <= FCTU_VEC_EXC;
    pulse(1, 0);
    wait_idle();
    chk(ghe_seen, 1);
    bad_addr <= 32'hFFFFFFFC;
    clr();
    wb(FCTU_OFS_CPB0, 1, 32'h00020000);
    wb(FCTU_OFS_CFG, 1, 32'h00000200);
    top_word <= 32'h00000000;
    pulse(1, 0);
    wait_idle();
    chk(ghe_seen, 1);
    chk(und_seen, 1);
    $display("test hard done");
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_fault();
    t_rtnc(32'h00000000, 0);
    t_mach();
    t_ghe(1, 1, FCTU_GHE_DSI_OK);
    t_ghe(1, 0, FCTU_GHE_DSI_FAIL);
    t_ghe(0, 1, 0);
    t_fault();
    t_rtnc(32'h00000001, 1);
    do_reset();
    t_hard();
    end_of_test();
  end
endmodule
